//--- logic/sck_consts.svh
`ifndef SCK_CONSTS_SVH
`define SCK_CONSTS_SVH

// Register byte addresses.
`define SCK_ADDR_CLK_CTRL 32'h4000_2000
`define SCK_ADDR_TRIM_CTRL 32'h4000_5c00
`define SCK_ADDR_USER_LP 32'h4000_5c04
`define SCK_ADDR_USER_HP 32'h4000_5c08
`define SCK_ADDR_WIN_MAX_LOW 32'h4000_5c0c
`define SCK_ADDR_WIN_MAX_HIGH 32'h4000_5c10
`define SCK_ADDR_WIN_MIN_LOW 32'h4000_5c14
`define SCK_ADDR_WIN_MIN_HIGH 32'h4000_5c18
`define SCK_ADDR_TRIM_STATUS 32'h4000_5c1c
`define SCK_ADDR_APPLIED_LP 32'h4000_5c20
`define SCK_ADDR_APPLIED_HP 32'h4000_5c24
`define SCK_ADDR_UNLOCK 32'h4000_5c28

// Reset values.
`define SCK_CLK_CTRL_RST 16'h00e0
`define SCK_TRIM_CTRL_RST 3'h0
`define SCK_WIN_RST 19'h0_0000
`define SCK_UNLOCK_RST 16'h0000

// Field positions.
`define SCK_CLK_CTRL_DIV_BIT 0
`define SCK_CLK_CTRL_SEL_LSB 3
`define SCK_CLK_CTRL_SEL_MSB 4
`define SCK_TRIM_CTRL_MODE_BIT 0
`define SCK_TRIM_CTRL_STEP_LSB 1
`define SCK_TRIM_CTRL_STEP_MSB 2
`define SCK_STATUS_PREC_BIT 0
`define SCK_STATUS_HP_CHG_BIT 1
`define SCK_STATUS_LP_CHG_BIT 2

// Widths and codes.
`define SCK_TRIM_W 9
`define SCK_WIN_W 19
`define SCK_WIN_LOW_W 16
`define SCK_TRIM_MAX 9'h1ff
`define SCK_SEL_LF 2'h2
`define SCK_SEL_EXT 2'h3

`endif

//--- logic/sck_pkg.sv
package sck_pkg;

  // Root clock source chosen by the source select field.
  typedef enum {
    SCK_ROOT_HF,
    SCK_ROOT_LF,
    SCK_ROOT_EXT
  } sck_root_t;

  // Trim operating mode.
  typedef enum {
    SCK_TRIM_USER,
    SCK_TRIM_SYSTEM
  } sck_trim_mode_t;

endpackage

//--- logic/sck_clock_trim.sv
`timescale 1ns/100ps
`include "sck_consts.svh"

module sck_clock_trim #(
  parameter logic [15:0] TRIM_UNLOCK_KEY = 16'h00a5, // Arbitrary value.
  parameter logic [8:0] FACTORY_TRIM_LP = 9'h100,
  parameter logic [8:0] FACTORY_TRIM_HP = 9'h100
) (
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  input wire logic [31:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [31:0] REG_RDATA_OUT,
  input wire logic HF_OSC_CLK_IN,
  input wire logic LF_OSC_CLK_IN,
  input wire logic EXT_CLK_IN,
  input wire logic OSC_LOW_PREC_SEL_IN,
  input wire logic PERIPH_CLK_EN_IN,
  input wire logic CORE_FREE_CLK_EN_IN,
  input wire logic MEM_CLK_EN_IN,
  input wire logic CONV_IF_CLK_EN_IN,
  input wire logic LIN_MEAS_VALID_IN,
  input wire logic [18:0] LIN_MEAS_VALUE_IN,
  output logic UNDIV_CLK_OUT,
  output logic CORE_CLK_OUT,
  output logic PERIPH_CLK_OUT,
  output logic CORE_FREE_CLK_OUT,
  output logic MEM_CLK_OUT,
  output logic CONV_IF_CLK_OUT,
  output logic HF_OSC_LOW_PREC_OUT,
  output logic [8:0] TRIM_LOW_PREC_OUT,
  output logic [8:0] TRIM_HIGH_PREC_OUT
);

  // Steps a trim value by the given count, saturating at both ends so a
  // long run of one-sided errors can never wrap the oscillator to the far end.
  function automatic logic [8:0] trim_step(input logic [8:0] value, input logic [2:0] count,
                                           input logic up, input logic down);
    logic [9:0] wide;
    wide = {1'b0, value};
    if (up) begin
      wide = wide + {7'h00, count};
      if (wide > {1'b0, `SCK_TRIM_MAX}) begin
        wide = {1'b0, `SCK_TRIM_MAX};
      end
    end else if (down) begin
      if (wide < {7'h00, count}) begin
        wide = 10'h000;
      end else begin
        wide = wide - {7'h00, count};
      end
    end
    return wide[8:0];
  endfunction

  // Registers.
  logic [15:0] clk_ctrl_reg;
  logic [15:0] clk_ctrl_next;
  logic [2:0] trim_ctrl_reg;
  logic [2:0] trim_ctrl_next;
  logic [8:0] user_lp_reg;
  logic [8:0] user_lp_next;
  logic [8:0] user_hp_reg;
  logic [8:0] user_hp_next;
  logic [8:0] applied_lp_reg;
  logic [8:0] applied_lp_next;
  logic [8:0] applied_hp_reg;
  logic [8:0] applied_hp_next;
  logic [18:0] win_min_reg;
  logic [18:0] win_min_next;
  logic [18:0] win_max_reg;
  logic [18:0] win_max_next;
  logic [15:0] unlock_reg;
  logic [15:0] unlock_next;
  logic armed_reg;
  logic armed_next;
  logic lp_chg_reg;
  logic lp_chg_next;
  logic hp_chg_reg;
  logic hp_chg_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic low_prec_reg;

  // Clock path registers.
  logic hf_s1_reg;
  logic hf_s2_reg;
  logic lf_s1_reg;
  logic lf_s2_reg;
  logic ext_s1_reg;
  logic ext_s2_reg;
  logic undiv_reg;
  logic undiv_next;
  logic div_reg;
  logic div_next;
  logic core_reg;
  logic core_next;
  logic periph_reg;
  logic free_reg;
  logic mem_reg;
  logic conv_reg;

  // Address decode.
  wire logic hit_clk_ctrl = (REG_ADDR_IN == `SCK_ADDR_CLK_CTRL);
  wire logic hit_trim_ctrl = (REG_ADDR_IN == `SCK_ADDR_TRIM_CTRL);
  wire logic hit_user_lp = (REG_ADDR_IN == `SCK_ADDR_USER_LP);
  wire logic hit_user_hp = (REG_ADDR_IN == `SCK_ADDR_USER_HP);
  wire logic hit_max_l = (REG_ADDR_IN == `SCK_ADDR_WIN_MAX_LOW);
  wire logic hit_max_h = (REG_ADDR_IN == `SCK_ADDR_WIN_MAX_HIGH);
  wire logic hit_min_l = (REG_ADDR_IN == `SCK_ADDR_WIN_MIN_LOW);
  wire logic hit_min_h = (REG_ADDR_IN == `SCK_ADDR_WIN_MIN_HIGH);
  wire logic hit_status = (REG_ADDR_IN == `SCK_ADDR_TRIM_STATUS);
  wire logic hit_appl_lp = (REG_ADDR_IN == `SCK_ADDR_APPLIED_LP);
  wire logic hit_appl_hp = (REG_ADDR_IN == `SCK_ADDR_APPLIED_HP);
  wire logic hit_unlock = (REG_ADDR_IN == `SCK_ADDR_UNLOCK);

  // A protected write lands only while the key from the previous write is armed.
  wire logic prot_ok = REG_WR_IN && armed_reg;
  wire logic key_write = REG_WR_IN && hit_unlock && (REG_WDATA_IN[15:0] == TRIM_UNLOCK_KEY);

  // Mode and step decode from the trim control register.
  sck_pkg::sck_trim_mode_t trim_mode;
  assign trim_mode = trim_ctrl_reg[`SCK_TRIM_CTRL_MODE_BIT] ?
    sck_pkg::SCK_TRIM_SYSTEM : sck_pkg::SCK_TRIM_USER;
  wire logic [1:0] step_code = trim_ctrl_reg[`SCK_TRIM_CTRL_STEP_MSB:`SCK_TRIM_CTRL_STEP_LSB];
  wire logic [2:0] step_count = {1'b0, step_code} + 3'h1;

  // Measurement window; the error is judged against the middle of the window,
  // so a longer bit time than the middle means the oscillator runs fast.
  wire logic [19:0] win_sum = {1'b0, win_min_reg} + {1'b0, win_max_reg};
  wire logic [18:0] win_mid = win_sum[19:1];
  wire logic in_window = (LIN_MEAS_VALUE_IN >= win_min_reg) && (LIN_MEAS_VALUE_IN <= win_max_reg);
  wire logic cal_event = LIN_MEAS_VALID_IN && in_window &&
    (trim_mode == sck_pkg::SCK_TRIM_SYSTEM);
  wire logic step_up = cal_event && (LIN_MEAS_VALUE_IN < win_mid);
  wire logic step_down = cal_event && (LIN_MEAS_VALUE_IN > win_mid);
  wire logic [8:0] lp_stepped = trim_step(applied_lp_reg, step_count, step_up, step_down);
  wire logic [8:0] hp_stepped = trim_step(applied_hp_reg, step_count, step_up, step_down);
  wire logic lp_hw_change = low_prec_reg && (lp_stepped != applied_lp_reg);
  wire logic hp_hw_change = !low_prec_reg && (hp_stepped != applied_hp_reg);

  // Register write path; a write of anything but the key disarms the lock.
  always_comb begin
    clk_ctrl_next = clk_ctrl_reg;
    trim_ctrl_next = trim_ctrl_reg;
    user_lp_next = user_lp_reg;
    user_hp_next = user_hp_reg;
    win_min_next = win_min_reg;
    win_max_next = win_max_reg;
    unlock_next = unlock_reg;
    armed_next = armed_reg;
    if (REG_WR_IN) begin
      armed_next = key_write;
      if (hit_unlock) begin
        unlock_next = REG_WDATA_IN[15:0];
      end
      if (hit_clk_ctrl) begin
        clk_ctrl_next = REG_WDATA_IN[15:0];
      end
      if (hit_min_l) begin
        win_min_next[15:0] = REG_WDATA_IN[15:0];
      end
      if (hit_min_h) begin
        win_min_next[18:16] = REG_WDATA_IN[2:0];
      end
      if (hit_max_l) begin
        win_max_next[15:0] = REG_WDATA_IN[15:0];
      end
      if (hit_max_h) begin
        win_max_next[18:16] = REG_WDATA_IN[2:0];
      end
      if (prot_ok && hit_trim_ctrl) begin
        trim_ctrl_next = REG_WDATA_IN[2:0];
      end
      if (prot_ok && hit_user_lp) begin
        user_lp_next = REG_WDATA_IN[8:0];
      end
      if (prot_ok && hit_user_hp) begin
        user_hp_next = REG_WDATA_IN[8:0];
      end
    end
  end

  // Applied trims mirror the user values in user mode and follow the
  // measured steps in system mode, only for the precision mode in use.
  always_comb begin
    applied_lp_next = applied_lp_reg;
    applied_hp_next = applied_hp_reg;
    if (trim_mode == sck_pkg::SCK_TRIM_USER) begin
      applied_lp_next = user_lp_reg;
      applied_hp_next = user_hp_reg;
    end else if (low_prec_reg) begin
      applied_lp_next = lp_stepped;
    end else begin
      applied_hp_next = hp_stepped;
    end
  end

  // Change flags: a hardware change in the same cycle as a status read wins.
  always_comb begin
    lp_chg_next = lp_chg_reg;
    hp_chg_next = hp_chg_reg;
    if (REG_RD_IN && hit_status) begin
      lp_chg_next = 1'b0;
      hp_chg_next = 1'b0;
    end
    if ((trim_mode == sck_pkg::SCK_TRIM_SYSTEM) && lp_hw_change) begin
      lp_chg_next = 1'b1;
    end
    if ((trim_mode == sck_pkg::SCK_TRIM_SYSTEM) && hp_hw_change) begin
      hp_chg_next = 1'b1;
    end
  end

  // Read path; unmapped addresses and reserved bits read as zero.
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (REG_RD_IN) begin
      if (hit_clk_ctrl) begin
        rdata_next = {16'h0000, clk_ctrl_reg};
      end else if (hit_trim_ctrl) begin
        rdata_next = {29'h0000_0000, trim_ctrl_reg};
      end else if (hit_user_lp) begin
        rdata_next = {23'h00_0000, user_lp_reg};
      end else if (hit_user_hp) begin
        rdata_next = {23'h00_0000, user_hp_reg};
      end else if (hit_appl_lp) begin
        rdata_next = {23'h00_0000, applied_lp_reg};
      end else if (hit_appl_hp) begin
        rdata_next = {23'h00_0000, applied_hp_reg};
      end else if (hit_min_l) begin
        rdata_next = {16'h0000, win_min_reg[15:0]};
      end else if (hit_min_h) begin
        rdata_next = {29'h0000_0000, win_min_reg[18:16]};
      end else if (hit_max_l) begin
        rdata_next = {16'h0000, win_max_reg[15:0]};
      end else if (hit_max_h) begin
        rdata_next = {29'h0000_0000, win_max_reg[18:16]};
      end else if (hit_status) begin
        rdata_next = {29'h0000_0000, lp_chg_reg, hp_chg_reg, low_prec_reg};
      end else if (hit_unlock) begin
        rdata_next = {16'h0000, unlock_reg};
      end
    end
  end

  // Register state. Trim values start at the factory defaults in user mode.
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      clk_ctrl_reg <= `SCK_CLK_CTRL_RST;
      trim_ctrl_reg <= `SCK_TRIM_CTRL_RST;
      user_lp_reg <= FACTORY_TRIM_LP;
      user_hp_reg <= FACTORY_TRIM_HP;
      applied_lp_reg <= FACTORY_TRIM_LP;
      applied_hp_reg <= FACTORY_TRIM_HP;
      win_min_reg <= `SCK_WIN_RST;
      win_max_reg <= `SCK_WIN_RST;
      unlock_reg <= `SCK_UNLOCK_RST;
      armed_reg <= 1'b0;
      lp_chg_reg <= 1'b0;
      hp_chg_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      low_prec_reg <= 1'b0;
    end else begin
      clk_ctrl_reg <= clk_ctrl_next;
      trim_ctrl_reg <= trim_ctrl_next;
      user_lp_reg <= user_lp_next;
      user_hp_reg <= user_hp_next;
      applied_lp_reg <= applied_lp_next;
      applied_hp_reg <= applied_hp_next;
      win_min_reg <= win_min_next;
      win_max_reg <= win_max_next;
      unlock_reg <= unlock_next;
      armed_reg <= armed_next;
      lp_chg_reg <= lp_chg_next;
      hp_chg_reg <= hp_chg_next;
      rdata_reg <= rdata_next;
      low_prec_reg <= OSC_LOW_PREC_SEL_IN;
    end
  end

  // Root source decode from the select field.
  wire logic [1:0] src_sel = clk_ctrl_reg[`SCK_CLK_CTRL_SEL_MSB:`SCK_CLK_CTRL_SEL_LSB];
  sck_pkg::sck_root_t root_src;
  assign root_src = (src_sel == `SCK_SEL_EXT) ? sck_pkg::SCK_ROOT_EXT :
    (src_sel == `SCK_SEL_LF) ? sck_pkg::SCK_ROOT_LF : sck_pkg::SCK_ROOT_HF;
  wire logic div_on = clk_ctrl_reg[`SCK_CLK_CTRL_DIV_BIT];

  // Root clock mux and divide by two. The sources are sampled on the system
  // clock, so the derived edges carry one system period of jitter and a source
  // change may shorten one phase; this trades edge accuracy for a single domain.
  always_comb begin
    case (root_src)
      sck_pkg::SCK_ROOT_HF: undiv_next = hf_s2_reg;
      sck_pkg::SCK_ROOT_LF: undiv_next = lf_s2_reg;
      sck_pkg::SCK_ROOT_EXT: undiv_next = ext_s2_reg;
      default: undiv_next = hf_s2_reg;
    endcase
    div_next = div_reg ^ (undiv_next && !undiv_reg);
    core_next = div_on ? div_next : undiv_next;
  end

  // Synchronisers and derived clocks. Gates come only from the enable inputs.
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) begin
      hf_s1_reg <= 1'b0;
      hf_s2_reg <= 1'b0;
      lf_s1_reg <= 1'b0;
      lf_s2_reg <= 1'b0;
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      undiv_reg <= 1'b0;
      div_reg <= 1'b0;
      core_reg <= 1'b0;
      periph_reg <= 1'b0;
      free_reg <= 1'b0;
      mem_reg <= 1'b0;
      conv_reg <= 1'b0;
    end else begin
      hf_s1_reg <= HF_OSC_CLK_IN;
      hf_s2_reg <= hf_s1_reg;
      lf_s1_reg <= LF_OSC_CLK_IN;
      lf_s2_reg <= lf_s1_reg;
      ext_s1_reg <= EXT_CLK_IN;
      ext_s2_reg <= ext_s1_reg;
      undiv_reg <= undiv_next;
      div_reg <= div_next;
      core_reg <= core_next;
      periph_reg <= core_next && PERIPH_CLK_EN_IN;
      free_reg <= core_next && CORE_FREE_CLK_EN_IN;
      mem_reg <= core_next && MEM_CLK_EN_IN;
      conv_reg <= core_next && CONV_IF_CLK_EN_IN;
    end
  end

  // Outputs straight from flip-flops.
  assign REG_RDATA_OUT = rdata_reg;
  assign UNDIV_CLK_OUT = undiv_reg;
  assign CORE_CLK_OUT = core_reg;
  assign PERIPH_CLK_OUT = periph_reg;
  assign CORE_FREE_CLK_OUT = free_reg;
  assign MEM_CLK_OUT = mem_reg;
  assign CONV_IF_CLK_OUT = conv_reg;
  assign HF_OSC_LOW_PREC_OUT = low_prec_reg;
  assign TRIM_LOW_PREC_OUT = applied_lp_reg;
  assign TRIM_HIGH_PREC_OUT = applied_hp_reg;

endmodule // sck_clock_trim

//--- tb/sck_clock_trim_assertions.sv
`timescale 1ns/100ps
`include "sck_consts.svh"

// Port-level checks on the clock and trim block; every figure is tied to its input cause.
module sck_clock_trim_chk (
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  input wire logic [31:0] REG_ADDR_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [31:0] REG_RDATA_OUT,
  input wire logic OSC_LOW_PREC_SEL_IN,
  input wire logic PERIPH_CLK_EN_IN,
  input wire logic MEM_CLK_EN_IN,
  input wire logic CORE_FREE_CLK_EN_IN,
  input wire logic CONV_IF_CLK_EN_IN,
  input wire logic LIN_MEAS_VALID_IN,
  input wire logic UNDIV_CLK_OUT,
  input wire logic CORE_CLK_OUT,
  input wire logic PERIPH_CLK_OUT,
  input wire logic MEM_CLK_OUT,
  input wire logic CORE_FREE_CLK_OUT,
  input wire logic CONV_IF_CLK_OUT,
  input wire logic HF_OSC_LOW_PREC_OUT,
  input wire logic [8:0] TRIM_LOW_PREC_OUT,
  input wire logic [8:0] TRIM_HIGH_PREC_OUT
);
  logic [2:0] wr_hist_reg;
  wire logic status_rd = REG_RD_IN && (REG_ADDR_IN == `SCK_ADDR_TRIM_STATUS);
  wire logic bus_quiet = (wr_hist_reg == 3'h0);

  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);

  // Writes reach the trims up to three cycles later, so recent writes are remembered.
  always_ff @(posedge CLK_IN) begin
    if (SRST_IN) wr_hist_reg <= 3'h0;
    else wr_hist_reg <= {wr_hist_reg[1:0], REG_WR_IN};
  end

  property p_prec_follow;
    !$past(SRST_IN) |-> HF_OSC_LOW_PREC_OUT == $past(OSC_LOW_PREC_SEL_IN);
  endproperty
  a_prec_follow: assert property (p_prec_follow) else $error("precision output not following input");

  property p_periph_gate;
    !$past(SRST_IN) |-> PERIPH_CLK_OUT == (CORE_CLK_OUT && $past(PERIPH_CLK_EN_IN));
  endproperty
  a_periph_gate: assert property (p_periph_gate) else $error("peripheral clock gating wrong");

  property p_mem_gate;
    !$past(SRST_IN) |-> MEM_CLK_OUT == (CORE_CLK_OUT && $past(MEM_CLK_EN_IN));
  endproperty
  a_mem_gate: assert property (p_mem_gate) else $error("memory clock gating wrong");

  property p_free_gate;
    !$past(SRST_IN) |-> CORE_FREE_CLK_OUT == (CORE_CLK_OUT && $past(CORE_FREE_CLK_EN_IN));
  endproperty
  a_free_gate: assert property (p_free_gate) else $error("core free clock gating wrong");

  property p_conv_gate;
    !$past(SRST_IN) |-> CONV_IF_CLK_OUT == (CORE_CLK_OUT && $past(CONV_IF_CLK_EN_IN));
  endproperty
  a_conv_gate: assert property (p_conv_gate) else $error("converter clock gating wrong");

  // A divide setting change may raise the core clock on a steady root level, so recent writes are left out.
  property p_core_on_root;
    $rose(CORE_CLK_OUT) && bus_quiet |-> $rose(UNDIV_CLK_OUT);
  endproperty
  a_core_on_root: assert property (p_core_on_root) else $error("core clock rose off a root edge");

  property p_trim_cause;
    $changed(TRIM_LOW_PREC_OUT) || $changed(TRIM_HIGH_PREC_OUT) |-> $past(LIN_MEAS_VALID_IN) || !bus_quiet;
  endproperty
  a_trim_cause: assert property (p_trim_cause) else $error("trim changed with no cause");

  property p_step_bound;
    $past(LIN_MEAS_VALID_IN) && bus_quiet |-> ({1'b0, TRIM_LOW_PREC_OUT} <= {1'b0, $past(TRIM_LOW_PREC_OUT)} + 10'h004)
      && ({1'b0, TRIM_LOW_PREC_OUT} + 10'h004 >= {1'b0, $past(TRIM_LOW_PREC_OUT)});
  endproperty
  a_step_bound: assert property (p_step_bound) else $error("trim stepped by more than four");

  property p_inactive_hold;
    $past(LIN_MEAS_VALID_IN) && bus_quiet |-> ($past(HF_OSC_LOW_PREC_OUT) ?
      TRIM_HIGH_PREC_OUT == $past(TRIM_HIGH_PREC_OUT) : TRIM_LOW_PREC_OUT == $past(TRIM_LOW_PREC_OUT));
  endproperty
  a_inactive_hold: assert property (p_inactive_hold) else $error("inactive precision trim moved");

  property p_flag_clear;
    status_rd && $past(status_rd) && !$past(LIN_MEAS_VALID_IN) |=> REG_RDATA_OUT[2:1] == 2'b00;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("change flags survived a status read");

  property p_prec_status;
    status_rd |=> REG_RDATA_OUT[0] == $past(HF_OSC_LOW_PREC_OUT);
  endproperty
  a_prec_status: assert property (p_prec_status) else $error("status precision bit wrong");
endmodule // sck_clock_trim_chk

bind sck_clock_trim sck_clock_trim_chk u_chk (.CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .REG_ADDR_IN(REG_ADDR_IN),
  .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
  .OSC_LOW_PREC_SEL_IN(OSC_LOW_PREC_SEL_IN), .PERIPH_CLK_EN_IN(PERIPH_CLK_EN_IN), .MEM_CLK_EN_IN(MEM_CLK_EN_IN),
  .CORE_FREE_CLK_EN_IN(CORE_FREE_CLK_EN_IN), .CONV_IF_CLK_EN_IN(CONV_IF_CLK_EN_IN),
  .LIN_MEAS_VALID_IN(LIN_MEAS_VALID_IN), .UNDIV_CLK_OUT(UNDIV_CLK_OUT), .CORE_CLK_OUT(CORE_CLK_OUT),
  .PERIPH_CLK_OUT(PERIPH_CLK_OUT), .MEM_CLK_OUT(MEM_CLK_OUT), .CORE_FREE_CLK_OUT(CORE_FREE_CLK_OUT),
  .CONV_IF_CLK_OUT(CONV_IF_CLK_OUT), .HF_OSC_LOW_PREC_OUT(HF_OSC_LOW_PREC_OUT),
  .TRIM_LOW_PREC_OUT(TRIM_LOW_PREC_OUT), .TRIM_HIGH_PREC_OUT(TRIM_HIGH_PREC_OUT));

//--- tb/test_system_clock_and_osc_trim.sv
`timescale 1ns/100ps
`include "sck_consts.svh"

module test_system_clock_and_osc_trim;
  localparam logic [15:0] KEY = 16'h00a5; // Arbitrary value.
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic hf = 1'b0;
  logic lf = 1'b0;
  logic ext = 1'b0;
  logic lp_sel = 1'b0;
  logic [3:0] en = 4'hf;
  logic meas = 1'b0;
  logic [18:0] meas_val = 19'h0;
  logic [31:0] rdata;
  logic undiv, core, lp_out, rd_d;
  logic [8:0] trim_lp, trim_hp, a, b, e_lp;
  logic [15:0] cc;
  logic [31:0] exp_q[$];
  int n_mismatch = 0;
  int comparisons = 0;
  int n_undiv = 0;
  int n_core = 0;
  int e;

  sck_clock_trim #(.TRIM_UNLOCK_KEY(KEY)) u_dut (.CLK_IN(clk), .SRST_IN(srst), .REG_ADDR_IN(addr),
    .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .HF_OSC_CLK_IN(hf),
    .LF_OSC_CLK_IN(lf), .EXT_CLK_IN(ext), .OSC_LOW_PREC_SEL_IN(lp_sel), .PERIPH_CLK_EN_IN(en[0]),
    .CORE_FREE_CLK_EN_IN(en[1]), .MEM_CLK_EN_IN(en[2]), .CONV_IF_CLK_EN_IN(en[3]), .LIN_MEAS_VALID_IN(meas),
    .LIN_MEAS_VALUE_IN(meas_val), .UNDIV_CLK_OUT(undiv), .CORE_CLK_OUT(core), .PERIPH_CLK_OUT(),
    .CORE_FREE_CLK_OUT(), .MEM_CLK_OUT(), .CONV_IF_CLK_OUT(), .HF_OSC_LOW_PREC_OUT(lp_out),
    .TRIM_LOW_PREC_OUT(trim_lp), .TRIM_HIGH_PREC_OUT(trim_hp));

  // Oscillators are scaled so that a short window tells the three sources apart.
  initial begin
    forever #2.5 clk = ~clk;
  end
  initial begin
    forever #30 hf = ~hf;
  end
  initial begin
    forever #240 lf = ~lf;
  end
  initial begin
    forever #60 ext = ~ext;
  end

  // Edge counters for the root and core clocks.
  always @(posedge undiv) n_undiv++;
  always @(posedge core) n_core++;

  // Read data stands one cycle only, so it is taken at the edge after the strobe.
  always @(posedge clk) begin
    if (rd_d === 1'b1) chk(rdata, exp_q.pop_front());
    rd_d <= rd;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic near(input int n, input int c);
    return (n >= c - 1) && (n <= c + 1);
  endfunction

  // Bus tasks leave their strobe up; the next task or idle takes it down, so back-to-back is free.
  task automatic wr_reg(input logic [31:0] a_in, input logic [31:0] d_in);
    @(posedge clk);
    wr <= 1'b1;
    rd <= 1'b0;
    addr <= a_in;
    wdata <= d_in;
  endtask

  task automatic rd_reg(input logic [31:0] a_in, input logic [31:0] e_in);
    exp_q.push_back(e_in);
    @(posedge clk);
    rd <= 1'b1;
    wr <= 1'b0;
    addr <= a_in;
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
    end
  endtask

  task automatic key_wr(input logic [31:0] a_in, input logic [31:0] d_in);
    wr_reg(`SCK_ADDR_UNLOCK, {16'h0, KEY});
    wr_reg(a_in, d_in);
  endtask

  task automatic pulse(input logic [18:0] v);
    @(posedge clk);
    meas <= 1'b1;
    meas_val <= v;
    @(posedge clk);
    meas <= 1'b0;
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // A hang is cut short well after the roughly twenty microseconds the tests need.
  initial begin
    #100000;
    n_mismatch++;
    finish_test();
  end

  // Main sequence.
  initial begin
    void'($urandom(32'h74d25d14));
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    idle(1);
    rd_reg(`SCK_ADDR_CLK_CTRL, 32'h00e0);
    rd_reg(`SCK_ADDR_TRIM_CTRL, 32'h0);
    rd_reg(`SCK_ADDR_USER_LP, 32'h100);
    rd_reg(32'h4000_5c30, 32'h0);
    idle(2);
    chk(32'(trim_lp), 32'h100);
    for (int i = 0; i < 8; i++) begin
      cc = {8'h00, 3'b111, 2'(i >> 1), 2'b00, 1'(i)};
      wr_reg(`SCK_ADDR_CLK_CTRL, {16'h0, cc});
      en <= 4'($urandom);
      rd_reg(`SCK_ADDR_CLK_CTRL, {16'h0, cc});
      idle(8);
      n_undiv = 0;
      n_core = 0;
      #2401;
      e = (i >> 1 == 2) ? 5 : (i >> 1 == 3) ? 20 : 40;
      chk(32'(near(n_undiv, e)), 32'h1);
      chk(32'(near(n_core, e >> (i & 1))), 32'h1);
    end
    // Keyed and unkeyed trim writes; the window write in between disarms the key.
    a = 9'h080 + 9'($urandom % 256);
    b = 9'($urandom);
    key_wr(`SCK_ADDR_USER_LP, {23'h0, a});
    wr_reg(`SCK_ADDR_USER_HP, {23'h0, b});
    wr_reg(`SCK_ADDR_UNLOCK, {16'h0, KEY});
    wr_reg(`SCK_ADDR_WIN_MAX_LOW, 32'h0300);
    wr_reg(`SCK_ADDR_USER_HP, {23'h0, b});
    wr_reg(`SCK_ADDR_WIN_MAX_HIGH, 32'h1);
    wr_reg(`SCK_ADDR_WIN_MIN_LOW, 32'h0100);
    wr_reg(`SCK_ADDR_WIN_MIN_HIGH, 32'h1);
    rd_reg(`SCK_ADDR_USER_HP, 32'h100);
    rd_reg(`SCK_ADDR_USER_LP, {23'h0, a});
    idle(3);
    chk(32'(trim_lp), 32'(a));
    lp_sel <= 1'b1;
    e_lp = a;
    // Window is 0x10100..0x10300 with its middle at 0x10200; every step code is used.
    for (int s = 0; s < 4; s++) begin
      key_wr(`SCK_ADDR_TRIM_CTRL, {29'h0, 2'(s), 1'b1});
      idle(2);
      pulse(19'h10180);
      pulse(19'h10180);
      pulse(19'h10280);
      pulse(19'h10380);
      pulse(19'h00180);
      pulse(19'h10200);
      e_lp = e_lp + 9'(s + 1);
      idle(1);
      chk(32'(trim_lp), 32'(e_lp));
      chk(32'(lp_out), 32'h1);
      rd_reg(`SCK_ADDR_TRIM_STATUS, 32'h5);
      rd_reg(`SCK_ADDR_TRIM_STATUS, 32'h1);
    end
    rd_reg(`SCK_ADDR_USER_LP, {23'h0, a});
    lp_sel <= 1'b0;
    idle(2);
    pulse(19'h10180);
    idle(1);
    chk(32'(trim_hp), 32'h104);
    rd_reg(`SCK_ADDR_TRIM_STATUS, 32'h2);
    // Back to user mode: applied trims follow the user values again and measurements are ignored.
    key_wr(`SCK_ADDR_TRIM_CTRL, 32'h0);
    idle(3);
    pulse(19'h10180);
    idle(2);
    chk(32'(trim_lp), 32'(a));
    chk(32'(trim_hp), 32'h100);
    rd_reg(`SCK_ADDR_TRIM_STATUS, 32'h0);
    idle(2);
    srst <= 1'b1;
    idle(3);
    srst <= 1'b0;
    idle(1);
    rd_reg(`SCK_ADDR_CLK_CTRL, 32'h00e0);
    idle(3);
    finish_test();
  end
endmodule // test_system_clock_and_osc_trim
